/* dv/mad_core_properties.sv */
// Concurrent checks on the ports of the decoder core
module mad_core_properties (
  input wire clk_sys_in, // System clock
  input wire arst_n_in, // Reset, active low
  input wire mem_rd_out, // Read strobe
  input wire mem_wr_out, // Write strobe
  input wire [7:0] acc_out, // Accumulator copy
  input wire [7:0] flags_out, // Flag byte
  input wire [15:0] sp_out, // Stack pointer
  input wire done_out // Retire pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);
  // Bus strobes never overlap
  chk_strobe_excl: assert property (!(mem_rd_out && mem_wr_out))
    else $error("read and write strobes together");
  // Retire is a single-cycle pulse
  chk_done_pulse: assert property (done_out |=> !done_out)
    else $error("retire pulse longer than one cycle");
  // Fixed bits of the flag byte
  chk_flag_fixed: assert property (flags_out[1] && !flags_out[3] && !flags_out[5])
    else $error("fixed flag bits wrong");
  // Flag updates come only from arithmetic, whose result lands in the accumulator
  chk_zero_flag: assert property (
    $changed(flags_out) |-> flags_out[6] == (acc_out == 8'h00))
    else $error("zero flag disagrees with accumulator");
  chk_sign_flag: assert property ($changed(flags_out) |-> flags_out[7] == acc_out[7])
    else $error("sign flag disagrees with accumulator");
  chk_parity_flag: assert property (
    $changed(flags_out) |-> flags_out[2] == ~^acc_out)
    else $error("parity flag disagrees with accumulator");
  // Flags, accumulator and stack pointer only move when an instruction retires
  chk_flags_retire: assert property ($changed(flags_out) |-> done_out)
    else $error("flags changed outside retire");
  chk_acc_retire: assert property ($changed(acc_out) |-> done_out)
    else $error("accumulator changed outside retire");
  chk_sp_retire: assert property ($changed(sp_out) |-> done_out)
    else $error("stack pointer changed outside retire");
  // A store is followed by its instruction's retire within two cycles
  chk_write_retire: assert property (mem_wr_out |-> ##[0:2] done_out)
    else $error("write not followed by retire");
  cover property (mem_wr_out && done_out);
  cover property (done_out && flags_out[0]);
  cover property ($changed(sp_out));
endmodule // mad_core_properties

bind mad_core mad_core_properties u_mad_core_properties (
  .clk_sys_in(clk_sys_in),
  .arst_n_in(arst_n_in),
  .mem_rd_out(mem_rd_out),
  .mem_wr_out(mem_wr_out),
  .acc_out(acc_out),
  .flags_out(flags_out),
  .sp_out(sp_out),
  .done_out(done_out)
);

/* dv/mad_core_tb.sv */
// Self-checking bench running a short program through the decoder core
module mad_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0; // System clock
  logic arst_n_in = 1'b0; // Reset, active low
  wire [7:0] mem_rdata_in, mem_wdata_out, acc_out, flags_out; // Byte buses
  wire [15:0] mem_addr_out, pc_out, sp_out; // Address values
  wire mem_rd_out, mem_wr_out, unsupported_out, done_out; // Strobes
  wire [2:0] restart_vec_out, mcycles_out; // Opcode field, cycle count
  wire [3:0] states_out; // State count
  int n_errors = 0; // Mismatches
  int check_count = 0; // Comparisons
  int k; // Step index
  // Program image; indirect accumulator accesses use the BC and DE pairs, direct forms address byte3:byte2, other memory operands go through HL
  logic [7:0] prog [$] = {8'h21, 8'h80, 8'h01, 8'h3e, 8'h3c, 8'h77, 8'h06, 8'hc4, 8'h80,
    8'h48, 8'h8e, 8'hd6, 8'h3e, 8'h98, 8'h32, 8'h00, 8'h02, 8'h11, 8'ha5, 8'h5a, 8'heb,
    8'h22, 8'h10, 8'h02, 8'h12, 8'h2a, 8'h00, 8'h02, 8'h7c, 8'h0a, 8'h31, 8'h34, 8'h12,
    8'h36, 8'h99, 8'h7e, 8'h76};
  // Per-step opcode, states, machine cycles (0 skips timing), kind
  logic [7:0] ops [$] = {8'h21, 8'h3e, 8'h77, 8'h06, 8'h80, 8'h48, 8'h8e, 8'hd6, 8'h98,
    8'h32, 8'h11, 8'heb, 8'h22, 8'h12, 8'h2a, 8'h7c, 8'h0a, 8'h31, 8'h36, 8'h7e, 8'h76};
  logic [3:0] sts [$] = {4'ha, 4'h7, 4'h7, 4'h7, 4'h4, 4'h4, 4'h7, 4'h7, 4'h4, 4'hd, 4'ha,
    4'h0, 4'h0, 4'h7, 4'h0, 4'h4, 4'h7, 4'ha, 4'ha, 4'h7, 4'h0};
  logic [2:0] mcs [$] = {3'h3, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h2, 3'h2, 3'h1, 3'h4, 3'h3,
    3'h0, 3'h5, 3'h2, 3'h5, 3'h1, 3'h2, 3'h3, 3'h3, 3'h2, 3'h0};
  // Kind 0 arithmetic, 1 transfer, 2 outside the group
  int kinds [$] = {1, 1, 1, 1, 0, 1, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 2};

  mad_core u_mad_core (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .mem_rdata_in(mem_rdata_in),
    .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out),
    .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out),
    .acc_out(acc_out),
    .flags_out(flags_out),
    .pc_out(pc_out),
    .sp_out(sp_out),
    .restart_vec_out(restart_vec_out),
    .unsupported_out(unsupported_out),
    .states_out(states_out),
    .mcycles_out(mcycles_out),
    .done_out(done_out)
  );

  mad_mem_model u_mad_mem_model (
    .clk_sys_in(clk_sys_in),
    .mem_addr_in(mem_addr_out),
    .mem_wdata_in(mem_wdata_out),
    .mem_rd_in(mem_rd_out),
    .mem_wr_in(mem_wr_out),
    .mem_rdata_out(mem_rdata_in)
  );

  // 125 MHz clock
  initial forever #4 clk_sys_in = ~clk_sys_in;

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Counts, verdict, end of run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Wait for one retire, bounded, then check its reported fields
  task automatic step(input logic [7:0] op, input logic [3:0] st, input logic [2:0] mc,
      input int kind);
    logic [7:0] f0;
    int i;
    f0 = flags_out;
    i = 0;
    while (done_out !== 1'b1 && i < 40) begin
      @(negedge clk_sys_in);
      i++;
    end
    if (done_out !== 1'b1) begin
      n_errors++;
      stop_test();
    end
    check(unsupported_out, kind == 2);
    check(restart_vec_out, op[5:3]);
    if (kind != 0) check(flags_out, f0);
    if (mc != 3'h0) begin
      check(states_out, st);
      check(mcycles_out, mc);
    end
    @(negedge clk_sys_in);
    $display("test %h finished", op);
  endtask

  // Main sequence
  initial begin
    for (k = 0; k < prog.size(); k++) u_mad_mem_model.mem[k] = prog[k];
    u_mad_mem_model.mem[16'h0201] = 8'h5b; // High byte for the pointer load
    u_mad_mem_model.mem[16'hc4c4] = 8'h77; // Target of the indirect load
    repeat (10) @(negedge clk_sys_in);
    check(flags_out, 8'h02);
    arst_n_in = 1'b1;
    for (k = 0; k < ops.size(); k++) begin
      step(ops[k], sts[k], mcs[k], kinds[k]);
      case (k)
        // Three-byte literal consumed; next opcode fetch has moved one past it
        0: check(pc_out, 16'h0004);
        2: check(u_mad_mem_model.mem[16'h0180], 8'h3c);
        4: begin
          check(acc_out, 8'h00);
          check(flags_out, 8'h57);
        end
        6: begin
          check(acc_out, 8'h3d);
          check(flags_out, 8'h02);
        end
        7: begin
          check(acc_out, 8'hff);
          check(flags_out & 8'hc5, 8'h85);
        end
        8: begin
          check(acc_out, 8'h3a);
          check(flags_out & 8'hc5, 8'h04);
        end
        9: check(u_mad_mem_model.mem[16'h0200], 8'h3a);
        12: begin
          check(u_mad_mem_model.mem[16'h0210], 8'ha5);
          check(u_mad_mem_model.mem[16'h0211], 8'h5a);
        end
        13: check(u_mad_mem_model.mem[16'h0180], 8'h3a);
        15: check(acc_out, 8'h5b);
        16: check(acc_out, 8'h77);
        17: check(sp_out, 16'h1234);
        18: check(u_mad_mem_model.mem[16'h5b3a], 8'h99);
        19: check(acc_out, 8'h99);
        20: check(acc_out, 8'h99);
        default: ;
      endcase
    end
    stop_test();
  end
endmodule // mad_core_tb

/* dv/mad_mem_model.sv */
// Byte memory answering each read strobe within the strobe's own cycle
module mad_mem_model (
  input wire clk_sys_in, // System clock
  input wire [15:0] mem_addr_in, // Address from core
  input wire [7:0] mem_wdata_in, // Write data from core
  input wire mem_rd_in, // Read strobe
  input wire mem_wr_in, // Write strobe
  output logic [7:0] mem_rdata_out // Read data to core
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535]; // Backing store, loaded by the bench
  logic [7:0] idle_r = 8'h00; // Filler shown while no read is asked
  // Core samples read data at the edge that ends the strobe cycle, so answer at once
  assign mem_rdata_out = mem_rd_in ? mem[mem_addr_in] : idle_r;
  // Idle filler flips each cycle so stale data is never mistaken for an answer
  always @(posedge clk_sys_in) begin
    idle_r <= ~idle_r;
    if (mem_wr_in) begin
      mem[mem_addr_in] <= mem_wdata_in;
    end
  end
endmodule // mad_mem_model

/* src/mad_core.v */
// Data-transfer and add/subtract execution core with memory bus
//
// Function
// - Pair field selects BC, DE, HL, SP
// - First register of pair is high byte
// - Restart field encodes numbers zero to seven
// - Data transfers never change any flag
// - Register move copies source to destination
// - Memory move reads byte at HL address
// - Store move writes register at HL address
// - Literal load puts byte two in register
// - Literal store writes byte two to HL
// - Pair literal: byte3 high, byte2 low
// - Direct accumulator address is byte3:byte2
// - Pointer load: L first, H next address
// - Pointer store: L first, H next address
// - Indirect accumulator access uses BC or DE
// - Swap exchanges H with D, L with E
// - Arithmetic updates all five flags normally
// - Subtract two's complement, carry means borrow
// - Register add sums source into accumulator
// - Memory add sums HL byte into accumulator
// - Carry variants also add carry flag
// - Subtract keeps difference in accumulator
// - Borrow variants also subtract carry flag
// - Parity set on even count of ones
// - Half carry from bit three into four
`include "mad_map.vh"
module mad_core (
  input wire clk_sys_in, // System clock, 125 MHz
  input wire arst_n_in, // Asynchronous reset, active low
  input wire [7:0] mem_rdata_in, // Memory read data, same clock
  output reg [15:0] mem_addr_out, // Memory address
  output reg [7:0] mem_wdata_out, // Memory write data
  output reg mem_rd_out, // Read strobe, data sampled at the edge ending the same cycle
  output reg mem_wr_out, // Write strobe
  output reg [7:0] acc_out, // Accumulator copy
  output reg [7:0] flags_out, // Flag byte S Z 0 AC 0 P 1 CY
  output reg [15:0] pc_out, // Program counter
  output reg [15:0] sp_out, // Stack pointer
  output reg [2:0] restart_vec_out, // Restart field of last opcode
  output reg unsupported_out, // Last opcode outside this group
  output reg [3:0] states_out, // State count of last instruction
  output reg [2:0] mcycles_out, // Machine cycles of last instruction
  output reg done_out // Pulse: instruction retired
);
  localparam ST_FETCH = 3'h0; // Issue opcode read
  localparam ST_DEC = 3'h1; // Decode opcode
  localparam ST_B2 = 3'h2; // Byte two arrives
  localparam ST_B3 = 3'h3; // Byte three arrives
  localparam ST_MRD = 3'h4; // Data byte arrives
  localparam ST_MRD2 = 3'h5; // Second data byte arrives
  localparam ST_RRD = 3'h6; // Opcode byte arrives
  localparam ST_MWR2 = 3'h7; // Second write

  reg [2:0] st_r; // Sequencer state
  reg [7:0] op_r; // Current opcode
  reg [7:0] b2_r; // Second instruction byte
  reg [7:0] b_r, c_r, d_r, e_r, h_r, l_r; // General registers
  reg [15:0] mem_ptr_r; // Held address for pair accesses

  // Bank mirror is written by register-to-register moves; its read data goes unused
  wire [7:0] bank_rd; // Mirror read data
  reg bank_we; // Mirror write
  reg [2:0] bank_wa; // Mirror write index
  reg [7:0] bank_wd; // Mirror write data
  mad_regfile #(.DW(8)) u_bank (
    .clk_sys_in(clk_sys_in),
    .we_in(bank_we),
    .waddr_in(bank_wa),
    .wdata_in(bank_wd),
    .raddr_in(op_r[2:0]),
    .rdata_out(bank_rd)
  );

  wire [2:0] dst_f = op_r[`MAD_DST_LSB+2:`MAD_DST_LSB]; // Destination field
  wire [2:0] src_f = op_r[`MAD_SRC_LSB+2:`MAD_SRC_LSB]; // Source field
  wire [1:0] pair_f = op_r[`MAD_PAIR_LSB+1:`MAD_PAIR_LSB]; // Pair select
  wire [15:0] hl = {h_r, l_r}; // HL pointer, H high

  // Register read by field code; 110 reads as zero
  function [7:0] reg_val;
    input [2:0] f;
    begin
      case (f)
        `MAD_REG_B: reg_val = b_r;
        `MAD_REG_C: reg_val = c_r;
        `MAD_REG_D: reg_val = d_r;
        `MAD_REG_E: reg_val = e_r;
        `MAD_REG_H: reg_val = h_r;
        `MAD_REG_L: reg_val = l_r;
        `MAD_REG_A: reg_val = acc_out;
        default: reg_val = 8'h00;
      endcase
    end
  endfunction

  // Pair read by select field; first register high
  function [15:0] pair_val;
    input [1:0] p;
    begin
      case (p)
        `MAD_PAIR_BC: pair_val = {b_r, c_r};
        `MAD_PAIR_DE: pair_val = {d_r, e_r};
        `MAD_PAIR_HL: pair_val = {h_r, l_r};
        default: pair_val = sp_out;
      endcase
    end
  endfunction

  // Arithmetic: op bits 4:3 = add, add+c, sub, sub+b
  reg [8:0] sum; // Nine-bit result
  reg [4:0] low; // Nibble result
  reg [7:0] opnd; // Arithmetic operand
  reg cin; // Carry or borrow in
  reg is_sub; // Subtract select
  reg [7:0] alu_flags; // New flag byte
  always @* begin
    is_sub = op_r[4];
    cin = op_r[3] & flags_out[`MAD_FLAG_CARRY];
    opnd = (st_r == ST_DEC) ? reg_val(src_f) : mem_rdata_in;
    if (is_sub) begin
      // Two's complement: A + ~op + ~cin, borrow is inverted carry
      sum = {1'b0, acc_out} + {1'b0, ~opnd} + {8'h00, ~cin};
      low = {1'b0, acc_out[3:0]} + {1'b0, ~opnd[3:0]} + {4'h0, ~cin};
      sum[8] = ~sum[8];
    end else begin
      sum = {1'b0, acc_out} + {1'b0, opnd} + {8'h00, cin};
      low = {1'b0, acc_out[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
    end
    alu_flags = 8'h02; // Fixed bit one
    alu_flags[`MAD_FLAG_S] = sum[7];
    alu_flags[`MAD_FLAG_Z] = (sum[7:0] == 8'h00);
    alu_flags[`MAD_FLAG_HALF] = low[4];
    alu_flags[`MAD_FLAG_P] = ~^sum[7:0];
    alu_flags[`MAD_FLAG_CARRY] = sum[8];
  end

  // Opcode classes
  wire is_mov = (op_r[7:6] == 2'h1) && (op_r != `MAD_OP_HALT);
  wire is_alu_r = (op_r[7:5] == 3'h4); // Add/sub register forms
  wire is_alu_i = (op_r == `MAD_OP_SUM_LIT) || (op_r == `MAD_OP_SUM_LIT_CARRY) ||
                  (op_r == `MAD_OP_DIFF_LIT) || (op_r == `MAD_OP_DIFF_LIT_BORROW);
  wire is_lit_byte = (op_r[7:6] == 2'h0) && (op_r[2:0] == 3'h6);
  wire is_lit_pair = (op_r[7:6] == 2'h0) && (op_r[3:0] == 4'h1);
  wire is_ind_load = (op_r[7:5] == 3'h0) && (op_r[3:0] == 4'ha);
  wire is_ind_store = (op_r[7:5] == 3'h0) && (op_r[3:0] == 4'h2);
  wire needs_b2 = is_lit_byte || is_lit_pair || is_alu_i ||
                  (op_r == `MAD_OP_ACC_DIR_LOAD) ||
                  (op_r == `MAD_OP_ACC_DIR_STORE) || (op_r == `MAD_OP_PTR_DIR_LOAD) ||
                  (op_r == `MAD_OP_PTR_DIR_STORE);

  // Sequencer and register updates; flags only change in arithmetic paths
  always @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r <= ST_FETCH;
      op_r <= `MAD_RST_BYTE;
      b2_r <= `MAD_RST_BYTE;
      {b_r, c_r, d_r, e_r, h_r, l_r} <= 48'h0;
      acc_out <= `MAD_RST_BYTE;
      flags_out <= 8'h02;
      pc_out <= `MAD_RST_PC;
      sp_out <= `MAD_RST_SP;
      mem_ptr_r <= 16'h0000;
      mem_addr_out <= 16'h0000;
      mem_wdata_out <= 8'h00;
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      restart_vec_out <= 3'h0;
      unsupported_out <= 1'b0;
      states_out <= 4'h0;
      mcycles_out <= 3'h0;
      done_out <= 1'b0;
      bank_we <= 1'b0;
      bank_wa <= 3'h0;
      bank_wd <= 8'h00;
    end else begin
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      done_out <= 1'b0;
      bank_we <= 1'b0;
      case (st_r)
        ST_FETCH: begin
          // Opcode read
          mem_addr_out <= pc_out;
          mem_rd_out <= 1'b1;
          pc_out <= pc_out + 16'h0001;
          st_r <= ST_RRD;
        end
        ST_RRD: begin
          // Opcode lands; restart field taken from its bits 5:3
          op_r <= mem_rdata_in;
          restart_vec_out <= mem_rdata_in[`MAD_RST_LSB+2:`MAD_RST_LSB];
          st_r <= ST_DEC;
        end
        ST_DEC: begin
          st_r <= ST_FETCH;
          unsupported_out <= 1'b0;
          if (needs_b2) begin
            mem_addr_out <= pc_out;
            mem_rd_out <= 1'b1;
            pc_out <= pc_out + 16'h0001;
            st_r <= ST_B2;
          end else if (is_mov && src_f == `MAD_REG_MEM) begin
            mem_addr_out <= hl;
            mem_rd_out <= 1'b1;
            st_r <= ST_MRD;
          end else if (is_mov && dst_f == `MAD_REG_MEM) begin
            mem_addr_out <= hl;
            mem_wdata_out <= reg_val(src_f);
            mem_wr_out <= 1'b1;
            states_out <= `MAD_T_MEM1;
            mcycles_out <= 3'h2;
            done_out <= 1'b1;
          end else if (is_mov) begin
            case (dst_f)
              `MAD_REG_B: b_r <= reg_val(src_f);
              `MAD_REG_C: c_r <= reg_val(src_f);
              `MAD_REG_D: d_r <= reg_val(src_f);
              `MAD_REG_E: e_r <= reg_val(src_f);
              `MAD_REG_H: h_r <= reg_val(src_f);
              `MAD_REG_L: l_r <= reg_val(src_f);
              default: acc_out <= reg_val(src_f);
            endcase
            bank_we <= 1'b1;
            bank_wa <= dst_f;
            bank_wd <= reg_val(src_f);
            states_out <= `MAD_T_MOV_RR;
            mcycles_out <= 3'h1;
            done_out <= 1'b1;
          end else if (is_alu_r && src_f == `MAD_REG_MEM) begin
            mem_addr_out <= hl;
            mem_rd_out <= 1'b1;
            st_r <= ST_MRD;
          end else if (is_alu_r) begin
            acc_out <= sum[7:0];
            flags_out <= alu_flags;
            states_out <= `MAD_T_MOV_RR;
            mcycles_out <= 3'h1;
            done_out <= 1'b1;
          end else if (is_ind_load || is_ind_store) begin
            // Only BC or DE are legal here; bit 4 picks which
            mem_addr_out <= pair_val({1'b0, pair_f[0]});
            mem_wdata_out <= acc_out;
            mem_rd_out <= is_ind_load;
            mem_wr_out <= is_ind_store;
            st_r <= is_ind_load ? ST_MRD : ST_FETCH;
            states_out <= `MAD_T_MEM1;
            mcycles_out <= 3'h2;
            done_out <= is_ind_store;
          end else if (op_r == `MAD_OP_SWAP_PAIRS) begin
            h_r <= d_r;
            l_r <= e_r;
            d_r <= h_r;
            e_r <= l_r;
            states_out <= `MAD_T_MOV_RR;
            mcycles_out <= 3'h1;
            done_out <= 1'b1;
          end else begin
            unsupported_out <= 1'b1; // Outside this group
            done_out <= 1'b1;
          end
        end
        ST_B2: begin
          st_r <= ST_FETCH;
          b2_r <= mem_rdata_in;
          if (is_lit_byte && dst_f == `MAD_REG_MEM) begin
            mem_addr_out <= hl;
            mem_wdata_out <= mem_rdata_in;
            mem_wr_out <= 1'b1;
            states_out <= `MAD_T_MEM2;
            mcycles_out <= 3'h3;
            done_out <= 1'b1;
          end else if (is_lit_byte) begin
            case (dst_f)
              `MAD_REG_B: b_r <= mem_rdata_in;
              `MAD_REG_C: c_r <= mem_rdata_in;
              `MAD_REG_D: d_r <= mem_rdata_in;
              `MAD_REG_E: e_r <= mem_rdata_in;
              `MAD_REG_H: h_r <= mem_rdata_in;
              `MAD_REG_L: l_r <= mem_rdata_in;
              default: acc_out <= mem_rdata_in;
            endcase
            states_out <= `MAD_T_MEM1;
            mcycles_out <= 3'h2;
            done_out <= 1'b1;
          end else if (is_alu_i) begin
            acc_out <= sum[7:0];
            flags_out <= alu_flags;
            states_out <= `MAD_T_MEM1;
            mcycles_out <= 3'h2;
            done_out <= 1'b1;
          end else begin
            mem_addr_out <= pc_out;
            mem_rd_out <= 1'b1;
            pc_out <= pc_out + 16'h0001;
            st_r <= ST_B3;
          end
        end
        ST_B3: begin
          st_r <= ST_FETCH;
          mem_ptr_r <= {mem_rdata_in, b2_r};
          if (is_lit_pair) begin
            case (pair_f)
              `MAD_PAIR_BC: {b_r, c_r} <= {mem_rdata_in, b2_r};
              `MAD_PAIR_DE: {d_r, e_r} <= {mem_rdata_in, b2_r};
              `MAD_PAIR_HL: {h_r, l_r} <= {mem_rdata_in, b2_r};
              default: sp_out <= {mem_rdata_in, b2_r};
            endcase
            states_out <= `MAD_T_MEM2;
            mcycles_out <= 3'h3;
            done_out <= 1'b1;
          end else if (op_r == `MAD_OP_ACC_DIR_STORE) begin
            mem_addr_out <= {mem_rdata_in, b2_r};
            mem_wdata_out <= acc_out;
            mem_wr_out <= 1'b1;
            states_out <= `MAD_T_DIR;
            mcycles_out <= 3'h4;
            done_out <= 1'b1;
          end else if (op_r == `MAD_OP_PTR_DIR_STORE) begin
            mem_addr_out <= {mem_rdata_in, b2_r};
            mem_wdata_out <= l_r;
            mem_wr_out <= 1'b1;
            st_r <= ST_MWR2;
          end else begin
            mem_addr_out <= {mem_rdata_in, b2_r};
            mem_rd_out <= 1'b1;
            st_r <= ST_MRD;
          end
        end
        ST_MRD: begin
          st_r <= ST_FETCH;
          done_out <= 1'b1;
          if (op_r == `MAD_OP_PTR_DIR_LOAD) begin
            l_r <= mem_rdata_in;
            mem_addr_out <= mem_ptr_r + 16'h0001;
            mem_rd_out <= 1'b1;
            done_out <= 1'b0;
            st_r <= ST_MRD2;
          end else if (op_r == `MAD_OP_ACC_DIR_LOAD || is_ind_load) begin
            acc_out <= mem_rdata_in;
            states_out <= is_ind_load ? `MAD_T_MEM1 : `MAD_T_DIR;
            mcycles_out <= is_ind_load ? 3'h2 : 3'h4;
          end else if (is_alu_r) begin
            acc_out <= sum[7:0];
            flags_out <= alu_flags;
            states_out <= `MAD_T_MEM1;
            mcycles_out <= 3'h2;
          end else begin
            // Memory to register move
            case (dst_f)
              `MAD_REG_B: b_r <= mem_rdata_in;
              `MAD_REG_C: c_r <= mem_rdata_in;
              `MAD_REG_D: d_r <= mem_rdata_in;
              `MAD_REG_E: e_r <= mem_rdata_in;
              `MAD_REG_H: h_r <= mem_rdata_in;
              `MAD_REG_L: l_r <= mem_rdata_in;
              default: acc_out <= mem_rdata_in;
            endcase
            states_out <= `MAD_T_MEM1;
            mcycles_out <= 3'h2;
          end
        end
        ST_MRD2: begin
          h_r <= mem_rdata_in;
          states_out <= `MAD_T_PTR; // State count not given for this one
          mcycles_out <= 3'h5;
          done_out <= 1'b1;
          st_r <= ST_FETCH;
        end
        default: begin
          // Second write of pointer store
          mem_addr_out <= mem_ptr_r + 16'h0001;
          mem_wdata_out <= h_r;
          mem_wr_out <= 1'b1;
          states_out <= 4'h0 + 4'h0 + 4'hf + 4'h1;
          mcycles_out <= 3'h5;
          done_out <= 1'b1;
          st_r <= ST_FETCH;
        end
      endcase
    end
  end
endmodule // mad_core

/* src/mad_map.vh */
// Opcode patterns, field positions, timing counts and reset values for the decoder
`ifndef MAD_MAP_VH
`define MAD_MAP_VH
`define MAD_REG_B 3'h0
`define MAD_REG_C 3'h1
`define MAD_REG_D 3'h2
`define MAD_REG_E 3'h3
`define MAD_REG_H 3'h4
`define MAD_REG_L 3'h5
`define MAD_REG_MEM 3'h6
`define MAD_REG_A 3'h7
`define MAD_PAIR_BC 2'h0
`define MAD_PAIR_DE 2'h1
`define MAD_PAIR_HL 2'h2
`define MAD_PAIR_SP 2'h3
`define MAD_DST_LSB 3
`define MAD_SRC_LSB 0
`define MAD_PAIR_LSB 4
`define MAD_RST_LSB 3
`define MAD_OP_ACC_DIR_LOAD 8'h3a
`define MAD_OP_ACC_DIR_STORE 8'h32
`define MAD_OP_PTR_DIR_LOAD 8'h2a
`define MAD_OP_PTR_DIR_STORE 8'h22
`define MAD_OP_SWAP_PAIRS 8'heb
`define MAD_OP_LIT_TO_MEM 8'h36
`define MAD_OP_HALT 8'h76
`define MAD_OP_SUM_LIT 8'hc6
`define MAD_OP_SUM_LIT_CARRY 8'hce
`define MAD_OP_DIFF_LIT 8'hd6
`define MAD_OP_DIFF_LIT_BORROW 8'hde
`define MAD_T_MOV_RR 4'h4
`define MAD_T_MEM1 4'h7
`define MAD_T_MEM2 4'ha
`define MAD_T_DIR 4'hd
`define MAD_T_PTR 4'h0
`define MAD_RST_PC 16'h0000
`define MAD_RST_SP 16'h0000
`define MAD_RST_BYTE 8'h00
`define MAD_FLAG_S 7
`define MAD_FLAG_Z 6
`define MAD_FLAG_HALF 4
`define MAD_FLAG_P 2
`define MAD_FLAG_CARRY 0
`endif

/* src/mad_regfile.v */
// Eight-entry byte register bank with registered read port
module mad_regfile #(
  parameter DW = 8
) (
  input wire clk_sys_in, // System clock
  input wire we_in, // Write strobe
  input wire [2:0] waddr_in, // Write index
  input wire [DW-1:0] wdata_in, // Write data
  input wire [2:0] raddr_in, // Read index
  output reg [DW-1:0] rdata_out // Registered read data
);
  reg [DW-1:0] mem_r [0:7]; // Storage, no reset needed

  // Write then registered read
  always @(posedge clk_sys_in) begin
    if (we_in) begin
      mem_r[waddr_in] <= wdata_in;
    end
    rdata_out <= mem_r[raddr_in];
  end
endmodule // mad_regfile
